// File: cdcb_defines.svh
// Register offsets, field positions and reset values of the configuration bank.
// Assumes inclusion by the bank module and the testbench only.
`ifndef CDCB_DEFINES_SVH
`define CDCB_DEFINES_SVH

// Byte addresses of the AXI4-Lite register words.
`define CDCB_ADDR_ID 8'h00
`define CDCB_ADDR_CFG1 8'h04
`define CDCB_ADDR_MUX 8'h08
`define CDCB_ADDR_REV 8'h0C
`define CDCB_ADDR_FDC 8'h10
`define CDCB_ADDR_DRVID 8'h14
`define CDCB_ADDR_PAR 8'h18
`define CDCB_ADDR_SER2 8'h1C

// Card configuration one fields.
`define CDCB_CFG1_DRVMODE 2
`define CDCB_CFG1_MODE 3
`define CDCB_CFG1_KBLOCK 4
`define CDCB_CFG1_SLOCK 5
`define CDCB_CFG1_RST 8'h04

// Floppy options fields.
`define CDCB_FDC_HIZ 0
`define CDCB_FDC_DPOL 5
`define CDCB_FDC_TDRMODE 6
`define CDCB_FDC_FOUR 7
`define CDCB_FDC_RST 8'h20
`define CDCB_DRVID_RST 8'h00

// Parallel options fields.
`define CDCB_PAR_HIZ 0
`define CDCB_PAR_CLK 1
`define CDCB_PAR_EXT 4
`define CDCB_PAR_RST 8'hF2

// Second serial options fields.
`define CDCB_SER_HIZ 0
`define CDCB_SER_PWR 1
`define CDCB_SER_BUSY 2
`define CDCB_SER_BANK 7
`define CDCB_SER_RST 8'h02
`define CDCB_SER_WMASK 8'h83

// Reset value of the pin multiplexer and cycles held for strap capture.
`define CDCB_MUX_RST 8'h00
`define CDCB_STRAP_WAIT 2'h3

// AXI response codes.
`define CDCB_RESP_OKAY 2'b00
`define CDCB_RESP_SLVERR 2'b10

`endif

// File: cdcb_pkg.sv
// Types shared by the configuration bank.
// Assumes the defines header is compiled alongside.
package cdcb_pkg;

    // Pin multiplexer layout.
    typedef struct packed {
        logic reserved;
        logic pin44_density;
        logic [1:0] pin43_sel;
        logic pin48_density;
        logic ds_or_motor;
        logic pin46_kbd;
        logic pin45_rate;
    } cdcb_mux_t;

    // Parallel port mode codes.
    typedef enum logic [2:0] {
        CDCB_PAR_SPP = 3'h0,
        CDCB_PAR_BIDIR = 3'h1,
        CDCB_PAR_EPP17 = 3'h2,
        CDCB_PAR_EPP19 = 3'h3,
        CDCB_PAR_1284 = 3'h4,
        CDCB_PAR_RSV5 = 3'h5,
        CDCB_PAR_RSV6 = 3'h6,
        CDCB_PAR_1284_EPP = 3'h7
    } cdcb_par_mode_t;

    // Floppy function signals into the pin multiplexer, active high.
    typedef struct packed {
        logic motor_on_zero;
        logic motor_on_one;
        logic drive_select_zero;
        logic drive_select_one;
        logic rate_select_zero;
        logic density_high_rate;
    } cdcb_fdc_fn_t;

    // Write channel states.
    typedef enum logic [1:0] {
        CDCB_WR_IDLE = 2'b01,
        CDCB_WR_RESP = 2'b10
    } cdcb_wr_state_t;

endpackage : cdcb_pkg

// File: cdcb_bank.sv
// Card and device configuration register bank with an AXI4-Lite slave.
// Assumes one 100 MHz clock, strap and pad inputs from outside that clock,
// and floppy function signals from logic on the same clock, active high.
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "cdcb_defines.svh"

module cdcb_bank
    import cdcb_pkg::*;
#(
    parameter logic [7:0] CHIP_ID = 8'h5A,  // Arbitrary identity value.
    parameter logic [7:0] CHIP_REV = 8'h01  // Arbitrary revision value.
) (
    input wire logic core_clk,
    input wire logic rstn,
    // AXI4-Lite slave.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Strap pins.
    input wire logic base_strap_low,
    input wire logic base_strap_high,
    input wire logic mode_strap,
    // Function signals from the floppy, keyboard and serial logic.
    input wire cdcb_fdc_fn_t fdc_fn,
    input wire logic kbd_port_line_out,
    input wire logic infrared_transmit,
    input wire logic [1:0] tape_drive_index,
    input wire logic floppy_active,
    input wire logic pm_floppy_float,
    input wire logic pm_parallel_clk,
    input wire logic pm_serial_clk,
    input wire logic serial_busy,
    // Shared pads.
    input wire logic pin43_in,
    output logic pin43_out,
    output logic pin43_oe_n,
    output logic pin44_out,
    output logic pin45_out,
    output logic pin46_out,
    output logic pin46_oe_n,
    output logic pin48_out,
    output logic drive_select_zero_pin,
    output logic infrared_receive,
    output logic kbd_port_line_in,
    // Configuration outputs to the functions.
    output logic [1:0] base_select,
    output logic at_drive_mode,
    output logic dual_serial_mode,
    output logic kbd_cfg_locked,
    output logic floppy_float,
    output logic tape_upper_driven,
    output logic [1:0] tape_drive_identity,
    output logic four_drive,
    output logic parallel_clk_en,
    output logic parallel_ext_access,
    output cdcb_par_mode_t parallel_mode,
    output logic serial_clk_en,
    output logic serial_bank_access
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations.

    logic [7:0] cfg1_q;
    logic [7:0] mux_q;
    logic [7:0] fdc_q;
    logic [7:0] drvid_q;
    logic [7:0] par_q;
    logic [7:0] ser_q;
    logic [2:0] strap_s1_q;
    logic [2:0] strap_s2_q;
    logic [1:0] strap_wait_q;
    logic pin43_s1_q;
    logic pin43_s2_q;
    cdcb_mux_t mux;
    cdcb_wr_state_t wr_state_q;
    logic aw_held_q;
    logic w_held_q;
    logic [7:0] awaddr_q;
    logic [7:0] wdata_q;
    logic wen_q;
    logic [1:0] bresp_q;
    logic do_write;
    logic [7:0] rd_byte;
    logic rd_hit;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic rvalid_q;
    logic density_select;

    // Tells whether a byte address names a register of this bank.
    function automatic logic addr_hit(input logic [7:0] a);
        case (a)
            `CDCB_ADDR_ID, `CDCB_ADDR_CFG1, `CDCB_ADDR_MUX, `CDCB_ADDR_REV,
            `CDCB_ADDR_FDC, `CDCB_ADDR_DRVID, `CDCB_ADDR_PAR,
            `CDCB_ADDR_SER2: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    endfunction : addr_hit

    // Tells whether a write with these strobes to this address stores.
    function automatic logic wr_to(input logic [7:0] a, input logic [7:0] reg_addr,
                                   input logic en);
        wr_to = en && (a == reg_addr);
    endfunction : wr_to

    ////////////////////////////////////////////////////////////////////////
    // Strap and pad synchronisers.

    // Two flip-flops on every signal from outside the clock domain.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            strap_s1_q <= 3'h0;
            strap_s2_q <= 3'h0;
            pin43_s1_q <= 1'b0;
            pin43_s2_q <= 1'b0;
        end else begin
            strap_s1_q <= {mode_strap, base_strap_high, base_strap_low};
            strap_s2_q <= strap_s1_q;
            pin43_s1_q <= pin43_in;
            pin43_s2_q <= pin43_s1_q;
        end
    end

    // Counts the cycles after release until the synchronised straps are valid.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            strap_wait_q <= `CDCB_STRAP_WAIT;
        end else if (strap_wait_q != 2'h0) begin
            strap_wait_q <= strap_wait_q - 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write channel.

    // Address and data are taken in either order; the response follows both.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 8'h00;
            wen_q <= 1'b0;
            wr_state_q <= CDCB_WR_IDLE;
            bresp_q <= `CDCB_RESP_OKAY;
        end else begin
            case (wr_state_q)
                CDCB_WR_IDLE: begin
                    if (s_axi_awvalid && s_axi_awready) begin
                        aw_held_q <= 1'b1;
                        awaddr_q <= s_axi_awaddr;
                    end
                    if (s_axi_wvalid && s_axi_wready) begin
                        w_held_q <= 1'b1;
                        wdata_q <= s_axi_wdata[7:0];
                        wen_q <= s_axi_wstrb[0];
                    end
                    if (do_write) begin
                        aw_held_q <= 1'b0;
                        w_held_q <= 1'b0;
                        bresp_q <= addr_hit(awaddr_q) ? `CDCB_RESP_OKAY : `CDCB_RESP_SLVERR;
                        wr_state_q <= CDCB_WR_RESP;
                    end
                end
                CDCB_WR_RESP: begin
                    if (s_axi_bready) begin
                        wr_state_q <= CDCB_WR_IDLE;
                    end
                end
                default: wr_state_q <= CDCB_WR_IDLE;
            endcase
        end
    end

    // Handshakes; the write lands one cycle after both halves are held.
    assign s_axi_awready = (wr_state_q == CDCB_WR_IDLE) && !aw_held_q;
    assign s_axi_wready = (wr_state_q == CDCB_WR_IDLE) && !w_held_q;
    assign do_write = (wr_state_q == CDCB_WR_IDLE) && aw_held_q && w_held_q;
    assign s_axi_bvalid = (wr_state_q == CDCB_WR_RESP);
    assign s_axi_bresp = bresp_q;

    ////////////////////////////////////////////////////////////////////////
    // Card control registers.

    // Card configuration one: straps, drive mode, locks and scratch bits.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cfg1_q <= `CDCB_CFG1_RST;
        end else begin
            if (strap_wait_q != 2'h0) begin
                cfg1_q[1:0] <= strap_s2_q[1:0];
                cfg1_q[`CDCB_CFG1_MODE] <= strap_s2_q[2];
            end else if (do_write && wr_to(awaddr_q, `CDCB_ADDR_CFG1, wen_q)) begin
                cfg1_q[1:0] <= wdata_q[1:0];
                cfg1_q[`CDCB_CFG1_DRVMODE] <= wdata_q[`CDCB_CFG1_DRVMODE];
                cfg1_q[`CDCB_CFG1_KBLOCK] <= wdata_q[`CDCB_CFG1_KBLOCK];
                // The lock only sets; reset alone clears it.
                cfg1_q[`CDCB_CFG1_SLOCK] <= cfg1_q[`CDCB_CFG1_SLOCK] | wdata_q[`CDCB_CFG1_SLOCK];
                if (!cfg1_q[`CDCB_CFG1_SLOCK]) begin
                    cfg1_q[7:6] <= wdata_q[7:6];
                end
            end
        end
    end

    // Pin multiplexer: held at zero in full infrared mode.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            mux_q <= `CDCB_MUX_RST;
        end else if (!cfg1_q[`CDCB_CFG1_MODE]) begin
            mux_q <= `CDCB_MUX_RST;
        end else if (do_write && wr_to(awaddr_q, `CDCB_ADDR_MUX, wen_q)) begin
            mux_q <= {1'b0, wdata_q[6:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Device option registers.

    // Floppy options and drive identity.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            fdc_q <= `CDCB_FDC_RST;
            drvid_q <= `CDCB_DRVID_RST;
        end else if (do_write) begin
            if (wr_to(awaddr_q, `CDCB_ADDR_FDC, wen_q)) begin
                fdc_q <= {wdata_q[7:5], 4'h0, wdata_q[0]};
            end
            if (wr_to(awaddr_q, `CDCB_ADDR_DRVID, wen_q)) begin
                drvid_q <= {4'h0, wdata_q[3:0]};
            end
        end
    end

    // Parallel and second serial options; busy is never stored.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            par_q <= `CDCB_PAR_RST;
            ser_q <= `CDCB_SER_RST;
        end else if (do_write) begin
            if (wr_to(awaddr_q, `CDCB_ADDR_PAR, wen_q)) begin
                par_q <= {wdata_q[7:4], 2'b00, wdata_q[1:0]};
            end
            if (wr_to(awaddr_q, `CDCB_ADDR_SER2, wen_q)) begin
                ser_q <= wdata_q & `CDCB_SER_WMASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel.

    // Read data mux; revision and identity are constants.
    always_comb begin
        rd_byte = 8'h00;
        case (s_axi_araddr)
            `CDCB_ADDR_ID: rd_byte = CHIP_ID;
            `CDCB_ADDR_CFG1: rd_byte = cfg1_q;
            `CDCB_ADDR_MUX: rd_byte = mux_q;
            `CDCB_ADDR_REV: rd_byte = CHIP_REV;
            `CDCB_ADDR_FDC: rd_byte = fdc_q;
            `CDCB_ADDR_DRVID: rd_byte = drvid_q;
            `CDCB_ADDR_PAR: rd_byte = par_q;
            `CDCB_ADDR_SER2: rd_byte = ser_q | {5'h00, serial_busy, 2'b00};
            default: rd_byte = 8'h00;
        endcase
        rd_hit = addr_hit(s_axi_araddr);
    end

    // One read at a time; data registered one cycle after the address.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `CDCB_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q <= {24'h00_0000, rd_byte};
            rresp_q <= rd_hit ? `CDCB_RESP_OKAY : `CDCB_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    ////////////////////////////////////////////////////////////////////////
    // Pin multiplexer.

    assign mux = cdcb_mux_t'(mux_q);

    // Pin 45, pin 48 and pin 44 outputs.
    assign pin45_out = mux.pin45_rate ? fdc_fn.rate_select_zero : fdc_fn.motor_on_zero;
    assign pin48_out = mux.pin48_density ? density_select
        : (fdc_fn.drive_select_one | (mux.ds_or_motor & mux.pin46_kbd & fdc_fn.motor_on_one));
    assign pin44_out = mux.pin44_density ? density_select : infrared_transmit;

    // Pin 46 is motor one or the open-drain keyboard line, pulling low only.
    assign pin46_out = mux.pin46_kbd ? 1'b0 : fdc_fn.motor_on_one;
    assign pin46_oe_n = mux.pin46_kbd ? kbd_port_line_out : 1'b0;

    // Pin 43: receive, open-drain keyboard line, or rate select output.
    always_comb begin
        pin43_out = 1'b0;
        pin43_oe_n = 1'b1;
        if (mux.pin43_sel == 2'b11) begin
            pin43_out = fdc_fn.rate_select_zero;
            pin43_oe_n = 1'b0;
        end else if (mux.pin43_sel == 2'b01) begin
            pin43_oe_n = kbd_port_line_out;
        end
    end

    // Inputs seen by the infrared and keyboard functions, idle high when unrouted.
    assign infrared_receive = (mux.pin43_sel[0] == 1'b0) ? pin43_s2_q : 1'b1;
    assign kbd_port_line_in = (mux.pin43_sel == 2'b01) ? pin43_s2_q : 1'b1;

    // Drive select zero takes in motor zero only once its pin is reassigned.
    assign drive_select_zero_pin = fdc_fn.drive_select_zero |
        (mux.ds_or_motor & mux.pin45_rate & fdc_fn.motor_on_zero);

    ////////////////////////////////////////////////////////////////////////
    // Function controls.

    // Density level follows the polarity bit for the high rates.
    assign density_select = fdc_q[`CDCB_FDC_DPOL] ? fdc_fn.density_high_rate
                                                  : !fdc_fn.density_high_rate;

    assign base_select = cfg1_q[1:0];
    assign at_drive_mode = cfg1_q[`CDCB_CFG1_DRVMODE];
    assign dual_serial_mode = cfg1_q[`CDCB_CFG1_MODE];
    assign kbd_cfg_locked = cfg1_q[`CDCB_CFG1_KBLOCK];

    // Floppy pins float when disabled with the option set, or by power control.
    assign floppy_float = (!floppy_active && fdc_q[`CDCB_FDC_HIZ]) || pm_floppy_float;

    // Tape drive register upper bits and the drive identity shown there.
    assign tape_upper_driven = fdc_q[`CDCB_FDC_TDRMODE];
    assign four_drive = fdc_q[`CDCB_FDC_FOUR];
    assign tape_drive_identity = (tape_drive_index == 2'h1) ? drvid_q[3:2]
        : (tape_drive_index == 2'h0) ? drvid_q[1:0] : 2'b00;

    // Parallel clock, mode and extended register window.
    assign parallel_clk_en = par_q[`CDCB_PAR_CLK] & pm_parallel_clk;
    assign parallel_mode = cdcb_par_mode_t'(par_q[7:5]);
    assign parallel_ext_access = par_q[`CDCB_PAR_EXT] &&
        (parallel_mode == CDCB_PAR_1284 || parallel_mode == CDCB_PAR_1284_EPP);

    // Second serial clock and bank window.
    assign serial_clk_en = ser_q[`CDCB_SER_PWR] & pm_serial_clk;
    assign serial_bank_access = ser_q[`CDCB_SER_BANK];

endmodule : cdcb_bank

// File: cdcb_bank_asserts.sv
// Concurrent checks on the ports of the configuration bank.
// Bound to cdcb_bank from the testbench top file; one clock domain.
`timescale 1ns/10ps
module cdcb_bank_asserts
    import cdcb_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic base_strap_low,
    input wire logic base_strap_high,
    input wire logic mode_strap,
    input wire logic [1:0] base_select,
    input wire logic dual_serial_mode,
    input wire logic floppy_active,
    input wire logic pm_floppy_float,
    input wire logic floppy_float,
    input wire logic pm_parallel_clk,
    input wire logic parallel_clk_en,
    input wire logic parallel_ext_access,
    input wire cdcb_par_mode_t parallel_mode
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////
    // Bus answers come at fixed distances and refuse overlap.
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer not one cycle after address");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer not two cycles after taking");
    a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while answer pending");
    a_write_close: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer held after acceptance");
    // Straps land in the config fields within three edges of release.
    a_strap_load: assert property ($rose(rstn) |-> ##3 (base_select == {base_strap_high, base_strap_low})
        && (dual_serial_mode == mode_strap))
        else $error("strap values not captured");
    // Pad float and clock gating follow the power inputs; extended access needs a 1284 mode.
    a_float_power: assert property (pm_floppy_float |-> floppy_float)
        else $error("floppy pins not floated by power control");
    a_float_active: assert property (floppy_active && !pm_floppy_float |-> !floppy_float)
        else $error("floppy pins floated while active");
    a_par_clk_gate: assert property (!pm_parallel_clk |-> !parallel_clk_en)
        else $error("parallel clock enabled without power bit");
    a_ext_mode: assert property (parallel_ext_access |->
        parallel_mode inside {CDCB_PAR_1284, CDCB_PAR_1284_EPP})
        else $error("extended access outside 1284 modes");
    // Main scenarios reached.
    c_ext: cover property (parallel_ext_access);
    c_wr: cover property (s_axi_bvalid && s_axi_bready);
    c_float: cover property (floppy_float && !pm_floppy_float);
endmodule : cdcb_bank_asserts

// File: test_card_and_device_config_bank.sv
// Self-checking bench for the configuration bank over AXI4-Lite.
// Assumes the package, defines header and checker are compiled before it.
`timescale 1ns/10ps
`include "cdcb_defines.svh"
bind cdcb_bank cdcb_bank_asserts u_chk (.*);
module test_card_and_device_config_bank
    import cdcb_pkg::*;
;
    localparam logic [7:0] CID = 8'hA5; // Arbitrary identity value.
    localparam logic [7:0] CREV = 8'h03; // Arbitrary revision value.
    logic core_clk = 1'b0, rstn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic base_strap_low = 1'b1, base_strap_high = 1'b0, mode_strap = 1'b1, pin43_in = 1'b0;
    logic kbd_port_line_out = 1'b1, infrared_transmit = 1'b0, floppy_active = 1'b1, pm_floppy_float = 1'b0;
    logic pm_parallel_clk = 1'b0, pm_serial_clk = 1'b0, serial_busy = 1'b0;
    logic [1:0] tape_drive_index = 2'h0, s_axi_bresp, s_axi_rresp, base_select, tape_drive_identity;
    cdcb_fdc_fn_t fdc_fn = 6'h00;
    cdcb_par_mode_t parallel_mode;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pin43_out, pin43_oe_n;
    logic pin44_out, pin45_out, pin46_out, pin46_oe_n, pin48_out, drive_select_zero_pin, infrared_receive;
    logic kbd_port_line_in, at_drive_mode, dual_serial_mode, kbd_cfg_locked, floppy_float, tape_upper_driven;
    logic four_drive, parallel_clk_en, parallel_ext_access, serial_clk_en, serial_bank_access;
    int fail_count = 0, n_tests = 0;

    cdcb_bank #(.CHIP_ID(CID), .CHIP_REV(CREV)) dut (.*);

    // Free-running 100 MHz clock.
    always #5 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////
    // Records one comparison and reports a mismatch at once.
    task automatic ck(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, m, got, exp);
        end
    endtask : ck

    // One write; address and data released separately as each is taken.
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'h1,
                      input logic [1:0] er = 2'b00);
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready === 1'b1 && !ad) begin
                ad = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready === 1'b1 && !wd) begin
                wd = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end while (!(ad && wd));
        while (s_axi_bvalid !== 1'b1) @(posedge core_clk);
        ck(s_axi_bresp, er, "write response");
        s_axi_bready <= 1'b0;
    endtask : wr

    // One read compared against an expected byte and response.
    task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er = 2'b00);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge core_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge core_clk);
        ck(s_axi_rdata, {24'h00_0000, e}, "read data");
        ck(s_axi_rresp, er, "read response");
        s_axi_rready <= 1'b0;
    endtask : rc

    // Hardware reset with the given straps, then the strap capture window.
    task automatic hw_reset(input logic m, input logic [1:0] b);
        @(posedge core_clk);
        rstn <= 1'b0;
        mode_strap <= m;
        {base_strap_high, base_strap_low} <= b;
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge core_clk);
    endtask : hw_reset

    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run;
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////
    // Main test sequence.
    initial begin
        hw_reset(1'b1, 2'b01);
        rc(`CDCB_ADDR_ID, CID);
        rc(`CDCB_ADDR_REV, CREV);
        rc(`CDCB_ADDR_CFG1, 8'h0D);
        rc(`CDCB_ADDR_MUX, 8'h00);
        rc(`CDCB_ADDR_FDC, 8'h20);
        rc(`CDCB_ADDR_DRVID, 8'h00);
        rc(`CDCB_ADDR_PAR, 8'hF2);
        rc(`CDCB_ADDR_SER2, 8'h02);
        wr(`CDCB_ADDR_ID, 8'hFF);
        rc(`CDCB_ADDR_ID, CID);
        wr(8'h20, 8'h55, 4'h1, 2'b10);
        rc(8'h20, 8'h00, 2'b10);
        $display("test reset_values done");
        wr(`CDCB_ADDR_CFG1, 8'hC2);
        rc(`CDCB_ADDR_CFG1, 8'hCA);
        ck(at_drive_mode, 1'b0, "drive mode");
        ck(base_select, 2'b10, "base select");
        wr(`CDCB_ADDR_CFG1, 8'hF5);
        rc(`CDCB_ADDR_CFG1, 8'hFD);
        ck(kbd_cfg_locked, 1'b1, "keyboard lock set");
        wr(`CDCB_ADDR_CFG1, 8'h00);
        rc(`CDCB_ADDR_CFG1, 8'hE8);
        ck(kbd_cfg_locked, 1'b0, "keyboard lock clear");
        $display("test card_config done");
        for (int i = 0; i < 4; i++) begin
            wr(`CDCB_ADDR_MUX, {2'b00, i[1:0], 4'h0});
            repeat (3) @(posedge core_clk);
            ck(infrared_receive, i[0], "infrared receive routing");
            ck(kbd_port_line_in, i != 1, "keyboard line routing");
            ck(pin43_oe_n, i != 3, "shared pin drive");
        end
        wr(`CDCB_ADDR_MUX, 8'h9D);
        rc(`CDCB_ADDR_MUX, 8'h1D);
        wr(`CDCB_ADDR_MUX, 8'h00, 4'h0);
        rc(`CDCB_ADDR_MUX, 8'h1D);
        fdc_fn <= 6'h23;
        @(posedge core_clk);
        ck({pin45_out, pin48_out, drive_select_zero_pin, pin44_out}, 4'hE, "pin routing");
        ck({pin46_out, pin46_oe_n, pin43_out, pin43_oe_n}, 4'h1, "pin drive");
        $display("test pin_mux done");
        for (int m = 0; m < 8; m++) begin
            wr(`CDCB_ADDR_PAR, {m[2:0], 5'h12});
            rc(`CDCB_ADDR_PAR, {m[2:0], 5'h12});
            ck(parallel_mode, m[2:0], "parallel mode");
            ck(parallel_ext_access, m == 4 || m == 7, "extended access");
        end
        pm_parallel_clk <= 1'b1;
        @(posedge core_clk);
        ck(parallel_clk_en, 1'b1, "parallel clock on");
        wr(`CDCB_ADDR_PAR, 8'h10);
        ck(parallel_clk_en, 1'b0, "parallel clock off");
        $display("test parallel done");
        wr(`CDCB_ADDR_FDC, 8'hFF);
        rc(`CDCB_ADDR_FDC, 8'hE1);
        ck({tape_upper_driven, four_drive}, 2'b11, "tape and four drive");
        floppy_active <= 1'b0;
        @(posedge core_clk);
        ck(floppy_float, 1'b1, "float when disabled");
        wr(`CDCB_ADDR_DRVID, 8'hFE);
        rc(`CDCB_ADDR_DRVID, 8'h0E);
        for (int i = 0; i < 3; i++) begin
            tape_drive_index <= i[1:0];
            @(posedge core_clk);
            ck(tape_drive_identity, i == 0 ? 2'b10 : i == 1 ? 2'b11 : 2'b00, "drive identity");
        end
        wr(`CDCB_ADDR_FDC, 8'h00);
        ck({floppy_float, tape_upper_driven, four_drive}, 3'b000, "floppy options clear");
        pm_floppy_float <= 1'b1;
        @(posedge core_clk);
        ck(floppy_float, 1'b1, "float by power");
        pm_floppy_float <= 1'b0;
        floppy_active <= 1'b1;
        $display("test floppy done");
        serial_busy <= 1'b1;
        pm_serial_clk <= 1'b1;
        wr(`CDCB_ADDR_SER2, 8'hFF);
        rc(`CDCB_ADDR_SER2, 8'h87);
        ck({serial_clk_en, serial_bank_access}, 2'b11, "serial enables on");
        serial_busy <= 1'b0;
        wr(`CDCB_ADDR_SER2, 8'h00);
        rc(`CDCB_ADDR_SER2, 8'h00);
        ck({serial_clk_en, serial_bank_access}, 2'b00, "serial enables off");
        $display("test serial done");
        hw_reset(1'b0, 2'b11);
        rc(`CDCB_ADDR_CFG1, 8'h07);
        ck(dual_serial_mode, 1'b0, "infrared mode");
        wr(`CDCB_ADDR_MUX, 8'h9D);
        rc(`CDCB_ADDR_MUX, 8'h00);
        $display("test infrared_mode done");
        complete_run();
    end

    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        complete_run();
    end
endmodule : test_card_and_device_config_bank
